// file: hdl/srcp_pkg.sv
// Shared constants and types of the serial register control port.
package srcp_pkg;

  // ----------------------------------------------------------------
  // Configuration register file
  // ----------------------------------------------------------------
  localparam int          REG_COUNT    = 32;
  localparam logic [4:0]  CFG_ADDR     = 5'h00;
  localparam int          THREE_WIRE_B = 7;
  localparam int          LSB_FIRST_B  = 6;
  localparam int          SRESET_B     = 5;
  localparam int          PWR_DOWN_B   = 3;
  localparam logic [7:0]  DEF_REG      = 8'h00;
  localparam logic [4:0]  MIX_ADDR     = 5'h01;
  localparam logic [7:0]  DEF_MIX      = 8'h04;

  // ----------------------------------------------------------------
  // Register bus map and serial framing
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATUS_OFS   = 8'h80;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;
  localparam logic [2:0]  LAST_BIT     = 3'h7;

  typedef enum logic [1:0] {
    ST_INSTR,
    ST_DATA,
    ST_DONE
  } srcp_state_e;

  // Instruction byte as it arrives on the wire.
  typedef struct packed {
    logic       rd;
    logic [1:0] count;
    logic [4:0] addr;
  } srcp_instr_s;

  // One register write from the bus side.
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
    logic       lane0;
  } srcp_wreq_s;

  // Value a register takes after reset, or after a software reset for all but the configuration register.
  function automatic logic [7:0] reg_default(input logic [4:0] a);
    return (a == MIX_ADDR) ? DEF_MIX : DEF_REG;
  endfunction

  // Word-aligned bus addresses up to the status word are mapped.
  function automatic logic bus_mapped(input logic [7:0] a);
    return (a <= STATUS_OFS) && (a[1:0] == 2'h0);
  endfunction

endpackage

// file: hdl/srcp_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
module srcp_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Capture chain
  // ----------------------------------------------------------------
  // The first stage feeds only the second one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// file: hdl/srcp_axil.sv
// AXI4-Lite slave front end for the register file.
`timescale 1ns/1ps
module srcp_axil (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output srcp_pkg::srcp_wreq_s wreq,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data
);

  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic       w_lane0_r;
  logic       rd_pend_r;
  logic       fire;

  // A write fires once both address and data are held.
  assign fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb begin
    wreq.en    = fire && srcp_pkg::bus_mapped(aw_addr_r);
    wreq.addr  = aw_addr_r;
    wreq.data  = w_data_r;
    wreq.lane0 = w_lane0_r;
  end

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  // Address and data are taken in either order, one write at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= srcp_pkg::RESP_OKAY;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 8'h00;
      w_lane0_r     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_r     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_r     <= s_axi_wdata[7:0];
        w_lane0_r    <= s_axi_wstrb[0];
      end
      if (fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= srcp_pkg::bus_mapped(aw_addr_r) ?
                        srcp_pkg::RESP_OKAY : srcp_pkg::RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------
  // Data is looked up one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= srcp_pkg::RESP_OKAY;
      rd_addr       <= 8'h00;
      rd_pend_r     <= 1'b0;
    end else begin
      rd_pend_r <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_addr       <= s_axi_araddr;
        rd_pend_r     <= 1'b1;
      end
      if (rd_pend_r) begin
        s_axi_rvalid <= 1'b1;
        if (srcp_pkg::bus_mapped(rd_addr)) begin
          s_axi_rdata <= rd_data;
          s_axi_rresp <= srcp_pkg::RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= srcp_pkg::RESP_DECERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// file: hdl/srcp_top.sv
// Serial register control port with its register file and bus slave.
`timescale 1ns/1ps
module srcp_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sclk_pin,
  input  wire logic        port_select_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  output logic             serial_data_out_pin,
  output logic             serial_data_out_oe,
  output logic             power_down,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       sdi_s;
  logic       sclk_d_r;
  logic       rise;
  logic       fall;

  // Select resets to the idle, deselected level.
  srcp_sync #(.W(3), .RST(3'h2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({sclk_pin, port_select_n, sdio_in}),
    .q       (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  // Edges are found from the synchronised clock only; at 100 MHz this
  // resolves serial clocks up to the 15 MHz ceiling the master obeys.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  assign rise = sclk_s && !sclk_d_r;
  assign fall = !sclk_s && sclk_d_r;

  // ----------------------------------------------------------------
  // Register file and bus access
  // ----------------------------------------------------------------
  logic [7:0]          regs [srcp_pkg::REG_COUNT];
  srcp_pkg::srcp_wreq_s wreq;
  logic [7:0]          rd_addr;
  logic [31:0]         rd_data;
  logic                axi_wr;
  logic [4:0]          axi_idx;
  logic                spi_wr;
  logic [7:0]          spi_data;
  logic                sres;
  logic                three_wire;
  logic                lsb_first;
  logic [31:0]         status;
  srcp_pkg::srcp_state_e st_r;
  logic                rd_r;
  logic [4:0]          addr_r;

  srcp_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wreq          (wreq),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  // The status word is read-only; writes to it are accepted and dropped.
  assign axi_wr  = wreq.en && wreq.lane0 &&
                   (wreq.addr != srcp_pkg::STATUS_OFS);
  assign axi_idx = wreq.addr[6:2];

  // Live port configuration, no shadow copy.
  assign three_wire = regs[srcp_pkg::CFG_ADDR][srcp_pkg::THREE_WIRE_B];
  assign lsb_first  = regs[srcp_pkg::CFG_ADDR][srcp_pkg::LSB_FIRST_B];

  // A reset request from either side returns the other registers to their defaults.
  assign sres = (spi_wr && addr_r == srcp_pkg::CFG_ADDR &&
                 spi_data[srcp_pkg::SRESET_B]) ||
                (axi_wr && axi_idx == srcp_pkg::CFG_ADDR &&
                 wreq.data[srcp_pkg::SRESET_B]);

  // The reset bit self-clears so that it fires once per write.
  function automatic logic [7:0] stored(input logic [4:0] a,
                                        input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == srcp_pkg::CFG_ADDR) begin
      v[srcp_pkg::SRESET_B] = 1'b0;
    end
    return v;
  endfunction

  // The serial write is applied after the bus write so it wins a same-cycle clash.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < srcp_pkg::REG_COUNT; i++) begin
        regs[i] <= srcp_pkg::reg_default(5'(i));
      end
    end else begin
      if (axi_wr) begin
        regs[axi_idx] <= stored(axi_idx, wreq.data);
      end
      if (spi_wr) begin
        regs[addr_r] <= stored(addr_r, spi_data);
      end
      if (sres) begin
        for (int i = 1; i < srcp_pkg::REG_COUNT; i++) begin
          regs[i] <= srcp_pkg::reg_default(5'(i));
        end
      end
    end
  end

  // Power-down goes to the rest of the chip; the port ignores it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_down <= 1'b0;
    end else begin
      power_down <= regs[srcp_pkg::CFG_ADDR][srcp_pkg::PWR_DOWN_B];
    end
  end

  assign status  = {22'h0, !cs_n_s, rd_r, st_r, addr_r, 1'b0};
  assign rd_data = (rd_addr == srcp_pkg::STATUS_OFS) ? status :
                   {24'h0, regs[rd_addr[6:2]]};

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  srcp_pkg::srcp_instr_s nxt_instr;
  logic [2:0]            bit_cnt_r;
  logic [1:0]            left_r;
  logic [7:0]            sh_r;
  logic [7:0]            sh_nxt;
  logic [7:0]            tx_r;
  logic [4:0]            addr_nxt;
  logic                  byte_end;
  logic                  out_r;

  // Bit order follows the live configuration bit.
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b,
                                          input logic lsb);
    return lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // Five-bit arithmetic wraps both ways by itself.
  function automatic logic [4:0] step(input logic [4:0] a,
                                      input logic lsb);
    return lsb ? 5'(a + 5'h01) : 5'(a - 5'h01);
  endfunction

  assign sh_nxt    = shift_in(sh_r, sdi_s, lsb_first);
  assign nxt_instr = srcp_pkg::srcp_instr_s'(sh_nxt);
  assign byte_end  = rise && !cs_n_s && (bit_cnt_r == srcp_pkg::LAST_BIT);
  assign addr_nxt  = step(addr_r, lsb_first);
  assign spi_wr    = byte_end && (st_r == srcp_pkg::ST_DATA) && !rd_r;
  assign spi_data  = sh_nxt;

  // Phase sequencing; deselect restarts and drops any partial byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= srcp_pkg::ST_INSTR;
      bit_cnt_r <= 3'h0;
      left_r    <= 2'h0;
      rd_r      <= 1'b0;
      addr_r    <= 5'h00;
      sh_r      <= 8'h00;
    end else if (cs_n_s) begin
      st_r      <= srcp_pkg::ST_INSTR;
      bit_cnt_r <= 3'h0;
    end else if (rise && st_r != srcp_pkg::ST_DONE) begin
      sh_r      <= sh_nxt;
      bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      if (byte_end) begin
        case (st_r)
          srcp_pkg::ST_INSTR: begin
            st_r   <= srcp_pkg::ST_DATA;
            rd_r   <= nxt_instr.rd;
            left_r <= nxt_instr.count;
            addr_r <= nxt_instr.addr;
          end
          srcp_pkg::ST_DATA: begin
            addr_r <= addr_nxt;
            if (left_r == 2'h0) begin
              st_r <= srcp_pkg::ST_DONE;
            end else begin
              left_r <= 2'(left_r - 2'h1);
            end
          end
          default: begin
            st_r <= srcp_pkg::ST_DONE;
          end
        endcase
      end
    end
  end

  // Read data is loaded at each byte boundary and shifted out on falls.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_r  <= 8'h00;
      out_r <= 1'b0;
    end else if (byte_end && st_r == srcp_pkg::ST_INSTR) begin
      tx_r <= regs[nxt_instr.addr];
    end else if (byte_end && st_r == srcp_pkg::ST_DATA) begin
      tx_r <= regs[addr_nxt];
    end else if (fall && !cs_n_s && st_r == srcp_pkg::ST_DATA && rd_r) begin
      out_r <= lsb_first ? tx_r[0] : tx_r[7];
      tx_r  <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
  end

  // Pin drivers; only one of the two pins ever carries read data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdio_oe            <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else begin
      sdio_oe <= !cs_n_s && rd_r && st_r == srcp_pkg::ST_DATA &&
                 three_wire;
      serial_data_out_oe <= !cs_n_s && rd_r && st_r == srcp_pkg::ST_DATA &&
                            !three_wire;
    end
  end

  assign sdio_out            = out_r;
  assign serial_data_out_pin = out_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_instr_end;
    byte_end && st_r == srcp_pkg::ST_INSTR;
  endsequence

  sequence s_data_end;
    byte_end && st_r == srcp_pkg::ST_DATA;
  endsequence

  chk_instr_decode: assert property (
    s_instr_end |=> st_r == srcp_pkg::ST_DATA &&
      rd_r == $past(nxt_instr.rd) && left_r == $past(nxt_instr.count))
    else $error("instruction byte not decoded");

  chk_count_end: assert property (
    s_data_end ##0 (left_r == 2'h0) |=> st_r == srcp_pkg::ST_DONE)
    else $error("data phase length wrong");

  chk_addr_step: assert property (
    s_data_end ##0 lsb_first |=> addr_r == 5'($past(addr_r) + 5'h01))
    else $error("address did not count up");

  chk_addr_down: assert property (
    s_data_end ##0 !lsb_first |=> addr_r == 5'($past(addr_r) - 5'h01))
    else $error("address did not count down");

  chk_abort_restart: assert property (
    cs_n_s |-> !spi_wr ##1 (st_r == srcp_pkg::ST_INSTR &&
      bit_cnt_r == 3'h0))
    else $error("deselect did not restart the port");

  chk_byte_commit: assert property (
    spi_wr && addr_r != srcp_pkg::CFG_ADDR && !sres |=>
      regs[$past(addr_r)] == $past(spi_data))
    else $error("written byte not stored");

  chk_hiz_deselect: assert property (
    cs_n_s |=> !sdio_oe && !serial_data_out_oe)
    else $error("output driven while deselected");

  chk_three_wire: assert property (
    three_wire |=> !serial_data_out_oe)
    else $error("output pin driven in three-wire mode");

  chk_fall_only: assert property (
    $changed(out_r) |-> $past(fall))
    else $error("read bit changed off a falling edge");

  chk_soft_reset: assert property (
    sres |=> regs[srcp_pkg::MIX_ADDR] == srcp_pkg::DEF_MIX &&
      !regs[srcp_pkg::CFG_ADDR][srcp_pkg::SRESET_B])
    else $error("software reset incomplete");

endmodule

// file: verification/srcp_spi_master.sv
// Behavioural serial master that frames traffic for the register port.
`timescale 1ns/1ps
module srcp_spi_master (
  output logic     sclk,
  output logic     sel_n,
  output logic     mosi,
  input wire logic sdio_line,
  input wire logic sdo_line
);
  // -----------------------------------------------------------------
  // Idle state
  // -----------------------------------------------------------------
  // Clock rests low between frames; 125 ns period keeps it below 15 MHz.
  initial begin
    sclk  = 1'b0;
    sel_n = 1'b1;
    mosi  = 1'b0;
  end

  // -----------------------------------------------------------------
  // Frame
  // -----------------------------------------------------------------
  // Instruction byte first, then data; cut > 0 deselects after that
  // many bits. A released data line shows the inverse of its last value.
  task automatic xfer(input logic [7:0] ins, input int nb, input logic lsb,
                      input logic tw, input logic [31:0] wd, input int cut,
                      output logic [31:0] rd);
    int k;
    int j;
    int ix;
    logic [7:0] b;
    rd = 32'h0;
    sel_n = 1'b0;
    for (k = 0; k <= nb; k++) begin
      b = (k == 0) ? ins : wd[8*(k-1) +: 8];
      for (j = 0; j < 8; j++) begin
        ix = lsb ? j : 7 - j;
        if (cut > 0 && k * 8 + j >= cut) break;
        mosi = (k > 0 && ins[7]) ? ~mosi : b[ix];
        #62.5 sclk = 1'b1;
        if (k > 0) rd[8*(k-1)+ix] = tw ? sdio_line : sdo_line;
        #62.5 sclk = 1'b0;
      end
    end
    sel_n = 1'b1;
    mosi  = ~mosi;
    #250;
  endtask
endmodule

// file: verification/srcp_top_tb_top.sv
// Self-checking bench for the serial register control port.
`timescale 1ns/1ps
module srcp_top_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        sclk, sel_n, mosi, sdio_out, sdio_oe, sdo_pin, sdo_oe;
  logic        pwr, sdo_hold = 1'b0, tw = 1'b0, tw_bad = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  int          mismatches = 0;
  int          checks = 0;
  int          i;
  wire         sdio_line = sdio_oe ? sdio_out : mosi;
  wire         sdo_line = sdo_oe ? sdo_pin : ~sdo_hold;

  always #5 aclk = ~aclk;

  // -----------------------------------------------------------------
  // Pin watch
  // -----------------------------------------------------------------
  // Remembers the separate line's last level and flags the pin that
  // must stay quiet in the current line mode driving.
  always @(posedge aclk) begin
    if (sdo_oe) sdo_hold <= sdo_pin;
    if (tw ? sdo_oe : sdio_oe) tw_bad <= 1'b1;
  end

  srcp_spi_master srcp_spi_master_i (.sclk(sclk), .sel_n(sel_n),
    .mosi(mosi), .sdio_line(sdio_line), .sdo_line(sdo_line));

  srcp_top srcp_top_i (.aclk(aclk), .aresetn(aresetn), .sclk_pin(sclk),
    .port_select_n(sel_n), .sdio_in(sdio_line), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_data_out_pin(sdo_pin),
    .serial_data_out_oe(sdo_oe), .power_down(pwr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    mismatches++;
    $display("ERROR %0t: bus wait ran out", $time);
    summarize();
  endtask

  // Write: address and data offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200 && (awvalid || wvalid || !bvalid); n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (!awvalid && !wvalid && bvalid) bready <= 1'b0;
    end
    if (n >= 200) hang();
    chk(bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200 && (arvalid || !rvalid); n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    if (n >= 200) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Reads register index ix over the bus and compares the byte.
  task automatic reg_is(input logic [4:0] ix, input logic [7:0] e);
    axi_rd({1'b0, ix, 2'b00}, got, resp);
    chk(got, {24'h0, e});
  endtask

  task automatic spi(input logic [7:0] ins, input int nb, input logic lsb,
                     input logic [31:0] wd, input int cut);
    srcp_spi_master_i.xfer(ins, nb, lsb, tw, wd, cut, got);
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    reg_is(5'h00, 8'h00);
    reg_is(5'h01, 8'h04);
    axi_rd(8'h84, got, resp);
    chk(resp, 2'h3);
    spi(8'h64, 4, 1'b0, 32'h44332211, 0);
    for (i = 0; i < 4; i++) reg_is(5'(4 - i), 8'(8'h11 * (i + 1)));
    spi(8'ha3, 2, 1'b0, 32'h0, 0);
    chk(got, 32'h3322);
    axi_rd(8'h80, got, resp);
    chk(got, 32'h0000_0102);
    chk(resp, 2'h0);
    spi(8'h20, 2, 1'b0, 32'h5500, 0);
    reg_is(5'h1f, 8'h55);
    chk({31'h0, sdio_oe | sdo_oe}, 32'h0);
    spi(8'h04, 1, 1'b0, 32'hee, 12);
    spi(8'h84, 1, 1'b0, 32'h0, 3);
    spi(8'h84, 1, 1'b0, 32'h0, 0);
    chk(got, 32'h11);
    axi_wr(8'h00, 8'h40, 2'h0);
    spi(8'h3f, 2, 1'b1, 32'h4066, 0);
    spi(8'hbf, 2, 1'b1, 32'h0, 0);
    chk(got, 32'h4066);
    axi_wr(8'h00, 8'h88, 2'h0);
    tw = 1'b1;
    repeat (2) @(posedge aclk);
    chk({31'h0, pwr}, 32'h1);
    spi(8'h04, 1, 1'b0, 32'h5a, 0);
    spi(8'h84, 1, 1'b0, 32'h0, 0);
    chk(got, 32'h5a);
    chk({31'h0, tw_bad}, 32'h0);
    axi_wr(8'h00, 8'ha8, 2'h0);
    repeat (4) @(posedge aclk);
    reg_is(5'h00, 8'h88);
    reg_is(5'h01, 8'h04);
    reg_is(5'h04, 8'h00);
    axi_wr(8'h84, 8'h12, 2'h3);
    summarize();
  end
endmodule
